// ### verilog/pra_pkg.sv
// Package for the private register addressing and extension chassis block.
package pra_pkg;
    // ------------------------------------------------------------
    // Sizes and fixed values
    // ------------------------------------------------------------
    localparam int PRA_WORD_W = 32;
    localparam int PRA_NBYTES = 4;
    localparam int PRA_NREGS = 16;
    localparam int PRA_NBLK = 4;
    localparam int PRA_XOVER_LIMIT = 16;
    localparam int PRA_IDX_LSB = 12;
    localparam int PRA_IDX_MSB = 14;
    localparam logic [1:0] PRA_CPU_CHASSIS = 2'h0;
    localparam logic [31:0] PRA_IDLE_WORD = 32'hFFFFFFFF;
    localparam logic [31:0] PRA_RESET_WORD = 32'h00000000;

    typedef enum logic [1:0] {
        PRA_SRC_REG = 2'h0,
        PRA_SRC_XOVER = 2'h1,
        PRA_SRC_INDEX = 2'h2
    } pra_src_t;

    // Datapath requests from the processor.
    typedef struct packed {
        logic [3:0] reg_field;
        logic select_from_reg_field;
        logic core_crossover_enable;
        logic [31:0] prog_addr;
        logic select_from_index_field;
        logic [31:0] operand;
        logic pair_mode;
        logic pair_lsb;
        logic [3:0] page;
        logic reg_write;
        logic [3:0] byte_crossover_flags;
        logic [31:0] sum_bus;
        logic sum_to_reg_transfer;
        logic [3:0] sum_to_cable_transfer;
        logic not_io_fastreg_space;
    } pra_req_t;

    // Registered state of the block, apart from the storage array.
    typedef struct packed {
        logic [3:0] register_select_lines;
        logic [3:0] byte_write_enables;
        logic [31:0] wr_data;
        logic [31:0] cable_do;
        logic cable_oe;
        logic [31:0] rd_data;
        logic extension_unit_select;
        logic [3:0] read_byte_drive;
        logic [3:0] blk_en;
        logic [1:0] src;
    } pra_state_t;
endpackage : pra_pkg

// ### verilog/pra_top.sv
// Private register select, write gating, storage and extension chassis.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - No crossover: select from register field
// - Address below sixteen: select from program address
// - Indexing: low three selects from index bits
// - Pair operations derive select LSB separately
// - Byte enable from register write or crossover
// - Bytes written only on delayed write clock
// - Sum bus passed only under transfer enable
// - Up to three chassis, sixteen blocks total
// - Switch number matches chassis select bits
// - Unit select needs match and nonzero group
// - Top two page bits select chassis
// - Next two page bits pick one block
// - Top select bit picks element set
// - Read drive needs match and no writes
// - Unselected chassis keep read path off
// - Data cable lines are bidirectional
// - One word gate for registers, per byte gates for cables
// - Chassis write clock from sixth driver
// - Block control gated off in IO fast space
// - Inactive element holds data, outputs high
module pra_top
    import pra_pkg::*;
(
    input wire logic clk_in, // processor clock
    input wire logic nrst_in, // async reset, low active
    input wire pra_req_t req_in, // datapath request
    input wire logic fastreg_write_clock_in, // delayed write pulse
    input wire logic chassis_switch_high_in, // chassis switch bit 1
    input wire logic chassis_switch_low_in, // chassis switch bit 0
    input wire logic [31:0] cable_di_in, // cable data received
    output logic [3:0] register_select_lines_out, // register select
    output logic [3:0] byte_write_enables_out, // byte write enables
    output logic [31:0] cable_do_out, // cable data driven
    output logic cable_oe_out, // cable drive enable
    output logic [31:0] rd_data_out, // combined read word
    output logic extension_unit_select_out, // chassis unit select
    output logic [3:0] read_byte_drive_out, // chassis read drive
    output logic [3:0] blk_en_out // one-hot block enable
);
    pra_state_t st_ff;
    pra_state_t nxt_st;
    logic [31:0] mem [PRA_NBLK][PRA_NREGS];
    logic [3:0] rsel;
    logic chassis_sel_high;
    logic chassis_sel_low;
    logic block_sel_high;
    logic block_sel_low;
    logic match;
    logic not_page_group_zero;
    logic xover;

    assign chassis_sel_high = req_in.page[3];
    assign chassis_sel_low = req_in.page[2];
    assign block_sel_high = req_in.page[1];
    assign block_sel_low = req_in.page[0];
    assign xover = req_in.core_crossover_enable
        && (req_in.prog_addr < PRA_XOVER_LIMIT);
    // Chassis number 00 is the processor's own set; switches hold 01..11.
    assign match = (chassis_switch_high_in == chassis_sel_high)
        && (chassis_switch_low_in == chassis_sel_low);
    assign not_page_group_zero = ({chassis_sel_high, chassis_sel_low}
        != PRA_CPU_CHASSIS);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        rsel = 4'h0;
        // Crossover wins over the field; index only while indexing.
        if (xover)
        begin
            rsel = req_in.prog_addr[3:0];
            nxt_st.src = PRA_SRC_XOVER;
        end
        else if (req_in.select_from_index_field)
        begin
            rsel = {1'b0,
                req_in.operand[PRA_IDX_MSB:PRA_IDX_LSB]};
            nxt_st.src = PRA_SRC_INDEX;
        end
        else if (req_in.select_from_reg_field)
        begin
            rsel = req_in.reg_field;
            nxt_st.src = PRA_SRC_REG;
        end
        if (req_in.pair_mode)
        begin
            rsel[0] = req_in.pair_lsb;
        end
        nxt_st.register_select_lines = rsel;
        nxt_st.byte_write_enables = {4{req_in.reg_write}}
            | req_in.byte_crossover_flags;
        nxt_st.wr_data = req_in.sum_to_reg_transfer ? req_in.sum_bus
            : PRA_RESET_WORD;
        for (int b = 0; b < PRA_NBYTES; b++)
        begin
            nxt_st.cable_do[b*8 +: 8] = req_in.sum_to_cable_transfer[b]
                ? req_in.sum_bus[b*8 +: 8] : 8'h00;
        end
        nxt_st.cable_oe = |req_in.sum_to_cable_transfer;
        nxt_st.extension_unit_select = match
            && not_page_group_zero;
        // Read drive stays off unless matched, saving power elsewhere.
        nxt_st.read_byte_drive = (match && not_page_group_zero
            && (nxt_st.byte_write_enables == 4'h0))
            ? 4'hF : 4'h0;
        nxt_st.blk_en = 4'h0;
        // A page owned by another chassis must not touch blocks held here.
        if (req_in.not_io_fastreg_space
            && (match || !not_page_group_zero))
        begin
            nxt_st.blk_en[{block_sel_high, block_sel_low}] = 1'b1;
        end
        nxt_st.rd_data = PRA_IDLE_WORD;
        for (int k = 0; k < PRA_NBLK; k++)
        begin
            if (nxt_st.blk_en[k])
            begin
                nxt_st.rd_data = nxt_st.rd_data
                    & mem[k][rsel];
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_ff <= '0;
            // No block is enabled in reset, so the read word idles high.
            st_ff.rd_data <= PRA_IDLE_WORD;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Storage, written on the delayed write clock pulse
    // ------------------------------------------------------------
    // The write clock is taken as a synchronous strobe sampled each rising clock edge;
    // the chassis copy of this pulse arrives on the same input.
    genvar gb;
    generate
        for (gb = 0; gb < PRA_NBLK; gb++)
        begin : g_blk
            always_ff @(posedge clk_in)
            begin
                for (int b = 0; b < PRA_NBYTES; b++)
                begin
                    // Disabled blocks keep their data untouched.
                    if (fastreg_write_clock_in
                        && st_ff.blk_en[gb]
                        && st_ff.byte_write_enables[b])
                    begin
                        mem[gb][st_ff.register_select_lines][b*8 +: 8]
                            <= st_ff.extension_unit_select
                            ? cable_di_in[b*8 +: 8]
                            : st_ff.wr_data[b*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    assign register_select_lines_out = st_ff.register_select_lines;
    assign byte_write_enables_out = st_ff.byte_write_enables;
    assign cable_do_out = st_ff.cable_do;
    assign cable_oe_out = st_ff.cable_oe;
    assign rd_data_out = st_ff.rd_data;
    assign extension_unit_select_out = st_ff.extension_unit_select;
    assign read_byte_drive_out = st_ff.read_byte_drive;
    assign blk_en_out = st_ff.blk_en;

    // ------------------------------------------------------------
    // Checks: register select
    // ------------------------------------------------------------
    // Each select source is checked on its own so a priority slip shows.
    a_xover_select: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        xover && !req_in.pair_mode
        |=> register_select_lines_out == $past(req_in.prog_addr[3:0]))
        else $error("crossover select");
    a_field_select: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !xover && !req_in.select_from_index_field
        && req_in.select_from_reg_field && !req_in.pair_mode
        |=> register_select_lines_out == $past(req_in.reg_field))
        else $error("field select");
    a_index_select: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !xover && req_in.select_from_index_field && !req_in.pair_mode
        |=> register_select_lines_out
        == {1'b0, $past(req_in.operand[PRA_IDX_MSB:PRA_IDX_LSB])})
        else $error("index select");
    a_xover_first: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        xover && req_in.select_from_index_field && !req_in.pair_mode
        |=> register_select_lines_out == $past(req_in.prog_addr[3:0]))
        else $error("crossover priority");
    a_pair_lsb: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        req_in.pair_mode
        |=> register_select_lines_out[0] == $past(req_in.pair_lsb))
        else $error("pair select");

    // ------------------------------------------------------------
    // Checks: write path
    // ------------------------------------------------------------
    // Write data must be clean when the transfer gates are shut.
    a_byte_enable: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        req_in.reg_write |=> byte_write_enables_out == 4'hF)
        else $error("byte enable");
    a_byte_xover: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        req_in.byte_crossover_flags != 4'h0
        |=> (byte_write_enables_out & $past(req_in.byte_crossover_flags))
        == $past(req_in.byte_crossover_flags))
        else $error("crossover byte enable");
    a_sum_gate: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !req_in.sum_to_reg_transfer |=> st_ff.wr_data == 32'h0)
        else $error("sum gate");
    a_sum_pass: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        req_in.sum_to_reg_transfer
        |=> st_ff.wr_data == $past(req_in.sum_bus))
        else $error("sum pass");
    a_cable_idle: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        req_in.sum_to_cable_transfer == 4'h0
        |=> cable_do_out == 32'h0 && !cable_oe_out)
        else $error("cable idle");
    a_cable_byte: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        req_in.sum_to_cable_transfer[0]
        |=> cable_oe_out && cable_do_out[7:0] == $past(req_in.sum_bus[7:0]))
        else $error("cable byte");

    // ------------------------------------------------------------
    // Checks: chassis selection
    // ------------------------------------------------------------
    // Switches are sampled a cycle early, like the page bits they meet.
    a_unit_sel: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        extension_unit_select_out |-> $past(match && not_page_group_zero))
        else $error("unit select");
    a_chassis_match: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        extension_unit_select_out
        |-> {$past(chassis_switch_high_in), $past(chassis_switch_low_in)}
        == $past(req_in.page[3:2]))
        else $error("chassis match");
    a_own_group: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        req_in.page[3:2] == PRA_CPU_CHASSIS
        |=> !extension_unit_select_out && read_byte_drive_out == 4'h0)
        else $error("own group");
    a_read_drive: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        read_byte_drive_out != 4'h0
        |-> byte_write_enables_out == 4'h0 && extension_unit_select_out)
        else $error("read drive");
    a_drive_on: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        extension_unit_select_out && byte_write_enables_out == 4'h0
        |-> read_byte_drive_out == 4'hF)
        else $error("drive on");
    a_write_quiet: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        byte_write_enables_out != 4'h0 |-> read_byte_drive_out == 4'h0)
        else $error("drive during write");

    // ------------------------------------------------------------
    // Checks: block enables and read word
    // ------------------------------------------------------------
    // A stray block enable would corrupt storage on the next write pulse.
    a_blk_onehot: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        $onehot0(blk_en_out))
        else $error("block enable");
    a_block_pick: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        req_in.not_io_fastreg_space && req_in.page[3:2] == PRA_CPU_CHASSIS
        |=> blk_en_out == (4'h1 << $past(req_in.page[1:0])))
        else $error("block pick");
    a_foreign_blk: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !match && not_page_group_zero |=> blk_en_out == 4'h0)
        else $error("foreign block");
    a_io_block: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !req_in.not_io_fastreg_space |=> blk_en_out == 4'h0)
        else $error("io space");
    a_io_read: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !req_in.not_io_fastreg_space |=> rd_data_out == 32'hFFFFFFFF)
        else $error("io read");
    a_idle_high: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        blk_en_out == 4'h0 |-> rd_data_out == 32'hFFFFFFFF)
        else $error("idle read");
endmodule : pra_top

`default_nettype wire

// ### tb/pra_dp_model.sv
// Datapath model that feeds requests to the register block.
`timescale 1ns/10ps
`default_nettype none
module pra_dp_model
    import pra_pkg::*;
(
    input wire logic clk_in, // processor clock
    input wire logic rnd_in, // random requests when high
    input wire pra_req_t dir_in, // directed request
    output var pra_req_t req_out // request to the block
);
    integer seed = 32'h1A194B73;
    logic [127:0] r;
    initial req_out = '0;
    always @(posedge clk_in)
    begin
        r = {$random(seed), $random(seed), $random(seed), $random(seed)};
        // Half the addresses fall below sixteen, or crossover is never hit.
        if (r[120])
            r[113:86] = '0;
        req_out <= rnd_in ? pra_req_t'(r[119:0]) : dir_in;
    end
endmodule : pra_dp_model
`default_nettype wire

// ### tb/pra_top_tb.sv
// Self-checking bench for the register select and storage block.
`timescale 1ns/10ps
`default_nettype none
module pra_top_tb import pra_pkg::*;;
    logic clk = 0, nrst = 0, rnd = 0, wclk = 0, swh = 0, swl = 0;
    logic chk = 0, rdok = 0, eus_o, oe_o;
    logic [31:0] cdi = 32'h0000000F, exrd, rd_o, cdo_o;
    logic [3:0] sel_o, bwe_o, rbd_o, blk_o;
    pra_req_t dir = '0, req, q;
    pra_state_t st = '0, ex;
    logic [31:0] mem [4][16];
    logic [3:0] vld [4][16] = '{default: 4'h0};
    int checks = 0, miscompares = 0, cyc = 0;
    pra_dp_model PART (.clk_in(clk), .rnd_in(rnd), .dir_in(dir),
        .req_out(req));
    pra_top DUT (.clk_in(clk), .nrst_in(nrst), .req_in(req),
        .fastreg_write_clock_in(wclk), .chassis_switch_high_in(swh),
        .chassis_switch_low_in(swl), .cable_di_in(cdi),
        .register_select_lines_out(sel_o), .byte_write_enables_out(bwe_o),
        .cable_do_out(cdo_o), .cable_oe_out(oe_o), .rd_data_out(rd_o),
        .extension_unit_select_out(eus_o), .read_byte_drive_out(rbd_o),
        .blk_en_out(blk_o));
    initial forever #50 clk = ~clk;
    function automatic logic [1:0] bix(logic [3:0] e);
        return {e[3] | e[2], e[3] | e[1]};
    endfunction : bix
    function automatic pra_state_t model(pra_req_t q, logic [1:0] sw,
        logic [31:0] di);
        pra_state_t e;
        logic [1:0] hi;
        e = '0;
        hi = q.page[3:2];
        if (q.core_crossover_enable && q.prog_addr < PRA_XOVER_LIMIT)
            e.register_select_lines = q.prog_addr[3:0];
        else if (q.select_from_index_field)
            e.register_select_lines = {1'b0, q.operand[14:12]};
        else if (q.select_from_reg_field)
            e.register_select_lines = q.reg_field;
        if (q.pair_mode)
            e.register_select_lines[0] = q.pair_lsb;
        e.byte_write_enables = {4{q.reg_write}} | q.byte_crossover_flags;
        for (int b = 0; b < 4; b++)
            if (q.sum_to_cable_transfer[b])
                e.cable_do[b*8+:8] = q.sum_bus[b*8+:8];
        e.cable_oe = |q.sum_to_cable_transfer;
        e.extension_unit_select = sw == hi && hi != PRA_CPU_CHASSIS;
        e.read_byte_drive = {4{e.extension_unit_select
            && e.byte_write_enables == 4'h0}};
        if (q.not_io_fastreg_space && (hi == PRA_CPU_CHASSIS || sw == hi))
            e.blk_en = 4'h1 << q.page[1:0];
        // Chassis writes take cable data; the processor takes the sum bus.
        e.wr_data = e.extension_unit_select ? di :
            (q.sum_to_reg_transfer ? q.sum_bus : 32'h00000000);
        return e;
    endfunction : model
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic put(input logic w);
        dir <= q;
        repeat (2) @(posedge clk);
        wclk <= w;
        @(posedge clk);
        wclk <= 1'b0;
    endtask : put
    always @(posedge clk)
    begin
        chk = nrst;
        cdi <= {cdi[30:0], ~cdi[31]};
        if (++cyc > 5000)
        begin
            miscompares++;
            summarize();
        end
        for (int k = 0; k < 4; k++)
            if (wclk && st.byte_write_enables[k] && st.blk_en != 4'h0)
            begin
                mem[bix(st.blk_en)][st.register_select_lines][k*8+:8] =
                    st.wr_data[k*8+:8];
                vld[bix(st.blk_en)][st.register_select_lines][k] = 1'b1;
            end
        // The block takes cable data at the write edge, after this shift.
        ex = model(req, {swh, swl}, {cdi[30:0], ~cdi[31]});
        rdok = !wclk && req.page[3:2] == 2'h0 && (ex.blk_en == 4'h0
            || vld[bix(ex.blk_en)][ex.register_select_lines] == 4'hF);
        exrd = ex.blk_en == 4'h0 ? PRA_IDLE_WORD :
            mem[bix(ex.blk_en)][ex.register_select_lines];
        st = ex;
    end
    always @(negedge clk)
        if (chk)
        begin
            check(32'(sel_o), 32'(st.register_select_lines));
            check(32'(bwe_o), 32'(st.byte_write_enables));
            check(cdo_o, st.cable_do);
            check(32'(oe_o), 32'(st.cable_oe));
            check(32'(eus_o), 32'(st.extension_unit_select));
            check(32'(rbd_o), 32'(st.read_byte_drive));
            check(32'(blk_o), 32'(st.blk_en));
            if (rdok)
                check(rd_o, exrd);
        end
    initial
    begin
        repeat (20) @(posedge clk);
        check(rd_o, PRA_IDLE_WORD);
        nrst <= 1'b1;
        for (int i = 0; i < 64; i++)
        begin
            q = '0;
            q.select_from_reg_field = 1'b1;
            q.reg_field = i[3:0];
            q.page = {2'h0, i[5:4]};
            q.reg_write = 1'b1;
            q.sum_to_reg_transfer = 1'b1;
            q.sum_bus = 32'h9E3779B9 * i;
            q.not_io_fastreg_space = 1'b1;
            put(1'b1);
        end
        // Addresses 4 to 27 straddle the crossover limit on purpose.
        for (int i = 0; i < 24; i++)
        begin
            q.core_crossover_enable = 1'b1;
            q.prog_addr = i + 4;
            q.reg_field = ~i[3:0];
            q.select_from_index_field = i[4];
            q.operand = 32'h00005000 * i;
            q.pair_mode = i[1];
            q.pair_lsb = i[2];
            q.reg_write = 1'b0;
            q.byte_crossover_flags = i[3:0] ^ 4'h5;
            q.page = {2'h0, i[1:0]};
            q.not_io_fastreg_space = i != 7;
            put(1'b1);
        end
        rnd <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            {swh, swl} <= s[1:0];
            repeat (200)
            begin
                @(posedge clk);
                wclk <= cdi[5];
            end
        end
        summarize();
    end
endmodule : pra_top_tb
`default_nettype wire
